// File: hw/bst_pkg.sv
package bst_pkg;

  // ----------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------
  localparam int          IR_WIDTH       = 4;
  localparam logic [3:0]  IR_EXTEST      = 4'h0;
  localparam logic [3:0]  IR_SAMPLE      = 4'h1;
  localparam logic [3:0]  IR_IDCODE      = 4'h2;
  localparam logic [3:0]  IR_HIGHZ       = 4'h4;
  localparam logic [3:0]  IR_BYPASS      = 4'hF;
  // Instruction loaded on controller reset
  localparam logic [3:0]  IR_RESET_VALUE = 4'h2;
  // Capture pattern, low two bits fixed at 01
  localparam logic [3:0]  IR_CAPTURE     = 4'h1;

  // ----------------------------------------------------------------
  // Identification register fields
  // ----------------------------------------------------------------
  localparam int          ID_WIDTH       = 32;
  localparam int          ID_VER_LSB     = 28;
  localparam int          ID_PART_LSB    = 12;
  localparam int          ID_MFR_LSB     = 1;

  // ----------------------------------------------------------------
  // Controller states and helper counts
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SHF_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR,
    ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHF_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } bst_state_t;

  localparam int          SYNC_STAGES    = 2;

endpackage

// File: hw/bst_tap.sv
// Function
// - Five TMS-high edges reach Test-Logic-Reset
// - No self reset at power-up
// - State changes on rising TCK by TMS
// - Test-Logic-Reset disables test logic
// - Run-Test-Idle active only if instruction needs
// - Select states branch on TMS
// - Capture-IR loads pattern ending 01
// - Shift-IR shifts TDI through to TDO
// - Exit1-IR picks Pause or Update; pause holds
// - Exit2-IR returns to Shift or Update
// - Update-IR latches instruction on falling TCK
// - Capture-DR loads selected data register
// - Data path mirrors instruction path
// - Four test inputs, one serial output
// - Port ignores TCK, TMS and TDI during power down; TRST still resets
// - Four-bit instruction code decode
// - Bypass captures zero in Capture-DR
// - 32-bit read-only identification register
// - High-impedance disables outputs, selects bypass
`timescale 1ns/1ps
`default_nettype none

module bst_tap #(
  parameter int          BSR_LEN = 8,
  parameter logic [3:0]  ID_VER  = 4'h0,   // Arbitrary value
  parameter logic [15:0] ID_PART = 16'h0001, // Arbitrary value
  parameter logic [10:0] ID_MFR  = 11'h001  // Arbitrary value
) (
  input  wire logic               ref_clk_i,
  input  wire logic               sys_rst_i,
  input  wire logic               tck_i,
  input  wire logic               tms_i,
  input  wire logic               tdi_i,
  input  wire logic               trst_n_i,
  input  wire logic               power_down_input_i,
  input  wire logic [BSR_LEN-1:0] pins_in_i,
  output logic                    tdo_o,
  output logic                    tdo_oe_o,
  output logic [BSR_LEN-1:0]      bsr_drive_o,
  output logic                    extest_o,
  output logic                    outputs_off_o,
  output logic                    test_active_o,
  output logic [3:0]              instr_o,
  output logic [3:0]              state_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The shift path needs at least one boundary cell
  if (BSR_LEN < 1) begin : g_bad_bsr_len
    $error("BSR_LEN must be at least 1");
  end
  // The synchroniser slices below assume exactly two stages
  if (bst_pkg::SYNC_STAGES != 2) begin : g_bad_sync
    $error("SYNC_STAGES must be 2");
  end
  // Identification fields must tile the word with bit 0 left for the marker
  if (bst_pkg::ID_WIDTH != 32 || bst_pkg::ID_VER_LSB != 28 ||
      bst_pkg::ID_PART_LSB != 12 || bst_pkg::ID_MFR_LSB != 1) begin : g_bad_id
    $error("identification field layout does not match the parameters");
  end
  // Instruction codes are decoded as four-bit values
  if (bst_pkg::IR_WIDTH != 4) begin : g_bad_ir
    $error("IR_WIDTH must be 4");
  end

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    // Two-stage synchronisers for every pin
    logic [bst_pkg::SYNC_STAGES-1:0] tck_s;
    logic [bst_pkg::SYNC_STAGES-1:0] tms_s;
    logic [bst_pkg::SYNC_STAGES-1:0] tdi_s;
    logic [bst_pkg::SYNC_STAGES-1:0] trst_s;
    logic [bst_pkg::SYNC_STAGES-1:0] pd_s;
    logic [BSR_LEN-1:0]              pins_s0;
    logic [BSR_LEN-1:0]              pins_s1;
    // Last synchronised TCK level, for edge detection
    logic                            tck_d;
    // Controller and instruction path
    bst_pkg::bst_state_t             state;
    logic [3:0]                      ir_shift;
    logic [3:0]                      ir;
    // Data registers
    logic                            bypass;
    logic [31:0]                     id_shift;
    logic [BSR_LEN-1:0]              bsr_shift;
    logic [BSR_LEN-1:0]              bsr_upd;
    // Serial output stage
    logic                            tdo;
    logic                            tdo_oe;
  } bst_regs_t;

  bst_regs_t r;
  bst_regs_t next_r;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // instruction decode
  // Unlisted codes fall through to the bypass stage
  function automatic logic sel_bsr(input logic [3:0] ins);
    return (ins == bst_pkg::IR_EXTEST) || (ins == bst_pkg::IR_SAMPLE);
  endfunction

  function automatic logic sel_id(input logic [3:0] ins);
    return ins == bst_pkg::IR_IDCODE;
  endfunction

  // fixed identification word, marker bit set
  // Bit 0 is the marker that tells this word from a bypass zero
  function automatic logic [31:0] make_id();
    logic [31:0] w;
    w = 32'h0000_0001;
    w[bst_pkg::ID_VER_LSB +: 4]   = ID_VER;
    w[bst_pkg::ID_PART_LSB +: 16] = ID_PART;
    w[bst_pkg::ID_MFR_LSB +: 11]  = ID_MFR;
    return w;
  endfunction

  // Serial bit of the data register that the instruction selects
  function automatic logic dr_out(input bst_regs_t s);
    if (sel_bsr(s.ir)) begin
      return s.bsr_shift[0];
    end else if (sel_id(s.ir)) begin
      return s.id_shift[0];
    end
    // bypass for HIGHZ and unknown codes
    return s.bypass;
  endfunction

  // next state by TMS
  // Every state takes a TMS-high path toward reset, so five ones always end there
  function automatic bst_pkg::bst_state_t nxt(input bst_pkg::bst_state_t s, input logic m);
    case (s)
      bst_pkg::ST_TLR:    return m ? bst_pkg::ST_TLR    : bst_pkg::ST_RTI;
      bst_pkg::ST_RTI:    return m ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
      bst_pkg::ST_SEL_DR: return m ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
      bst_pkg::ST_CAP_DR: return m ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SHF_DR;
      bst_pkg::ST_SHF_DR: return m ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SHF_DR;
      bst_pkg::ST_EX1_DR: return m ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAU_DR;
      bst_pkg::ST_PAU_DR: return m ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PAU_DR;
      bst_pkg::ST_EX2_DR: return m ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SHF_DR;
      bst_pkg::ST_UPD_DR: return m ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
      bst_pkg::ST_SEL_IR: return m ? bst_pkg::ST_TLR    : bst_pkg::ST_CAP_IR;
      bst_pkg::ST_CAP_IR: return m ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SHF_IR;
      bst_pkg::ST_SHF_IR: return m ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SHF_IR;
      bst_pkg::ST_EX1_IR: return m ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAU_IR;
      bst_pkg::ST_PAU_IR: return m ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PAU_IR;
      bst_pkg::ST_EX2_IR: return m ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SHF_IR;
      bst_pkg::ST_UPD_IR: return m ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
      default:            return bst_pkg::ST_TLR;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Decoded each cycle from the synchronised pins
  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic tdi;
  logic pd;
  logic [31:0] id_word;

  assign id_word = make_id();

  always_comb begin
    next_r = r;
    // ----------------------------------------------------------------
    // Synchronisers and edge detection
    // ----------------------------------------------------------------
    // Only the last stage of each synchroniser is read by logic
    next_r.tck_s  = {r.tck_s[0], tck_i};
    next_r.tms_s  = {r.tms_s[0], tms_i};
    next_r.tdi_s  = {r.tdi_s[0], tdi_i};
    next_r.trst_s = {r.trst_s[0], trst_n_i};
    next_r.pd_s   = {r.pd_s[0], power_down_input_i};
    // Pin levels settle through two stages before capture
    next_r.pins_s0 = pins_in_i;
    next_r.pins_s1 = r.pins_s0;
    // A TCK glitch shorter than a clock can be missed; TCK must stay slow
    next_r.tck_d  = r.tck_s[1];
    tms      = r.tms_s[1];
    tdi      = r.tdi_s[1];
    pd       = r.pd_s[1];
    tck_rise = r.tck_s[1] & ~r.tck_d & ~pd;
    tck_fall = ~r.tck_s[1] & r.tck_d & ~pd;

    // ----------------------------------------------------------------
    // Capture and shift on detected TCK rise
    // ----------------------------------------------------------------
    if (tck_rise) begin
      next_r.state = nxt(r.state, tms);
      case (r.state)
        bst_pkg::ST_CAP_IR: next_r.ir_shift = bst_pkg::IR_CAPTURE;
        // shift instruction stages
        // LSB leaves first on TDO; new bits enter at the top
        bst_pkg::ST_SHF_IR: next_r.ir_shift = {tdi, r.ir_shift[3:1]};
        bst_pkg::ST_CAP_DR: begin
          if (sel_bsr(r.ir)) begin
            next_r.bsr_shift = r.pins_s1;
          end else if (sel_id(r.ir)) begin
            next_r.id_shift = id_word;
          end else begin
            next_r.bypass = 1'b0;
          end
        end
        bst_pkg::ST_SHF_DR: begin
          if (sel_bsr(r.ir)) begin
            next_r.bsr_shift = {tdi, r.bsr_shift[BSR_LEN-1:1]};
          end else if (sel_id(r.ir)) begin
            next_r.id_shift = {tdi, r.id_shift[31:1]};
          end else begin
            next_r.bypass = tdi;
          end
        end
        default: begin
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Serial output and update on detected TCK fall
    // ----------------------------------------------------------------
    if (tck_fall) begin
      // TDO changes on falling TCK so the tester samples it stable
      next_r.tdo_oe = (r.state == bst_pkg::ST_SHF_IR) || (r.state == bst_pkg::ST_SHF_DR);
      if (r.state == bst_pkg::ST_SHF_IR) begin
        next_r.tdo = r.ir_shift[0];
      end else begin
        next_r.tdo = dr_out(r);
      end
      if (r.state == bst_pkg::ST_UPD_IR) begin
        next_r.ir = r.ir_shift;
      end
      // Boundary cells change only at the end of an update
      if (r.state == bst_pkg::ST_UPD_DR && sel_bsr(r.ir)) begin
        next_r.bsr_upd = r.bsr_shift;
      end
      if (r.state == bst_pkg::ST_TLR) begin
        next_r.ir = bst_pkg::IR_RESET_VALUE;
      end
    end

    // ----------------------------------------------------------------
    // Test reset
    // ----------------------------------------------------------------
    // Checked last so it overrides any TCK edge in the same cycle
    // test reset forces reset state
    if (!r.trst_s[1]) begin
      next_r.state  = bst_pkg::ST_TLR;
      next_r.ir     = bst_pkg::IR_RESET_VALUE;
      next_r.tdo_oe = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // only the system reset initialises; it also forces Test-Logic-Reset and IR_RESET_VALUE
  // Synchroniser flops start at idle levels so no false edge follows reset
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      r          <= '0;
      r.trst_s   <= 2'h3;
      r.state    <= bst_pkg::ST_TLR;
      r.ir       <= bst_pkg::IR_RESET_VALUE;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Output enable is cut at once in power down, ahead of the next fall
  // single serial output, driven only while shifting
  assign tdo_o         = r.tdo;
  assign tdo_oe_o      = r.tdo_oe & ~r.pd_s[1];
  assign bsr_drive_o   = r.bsr_upd;
  // test modes only away from reset state
  assign extest_o      = (r.ir == bst_pkg::IR_EXTEST) && (r.state != bst_pkg::ST_TLR);
  assign outputs_off_o = (r.ir == bst_pkg::IR_HIGHZ) && (r.state != bst_pkg::ST_TLR);
  // idle test logic unless instruction needs it
  assign test_active_o = (r.state == bst_pkg::ST_RTI) && (extest_o || outputs_off_o);
  assign instr_o       = r.ir;
  assign state_o       = r.state;

endmodule

`default_nettype wire

// File: test/bst_tap_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module bst_tap_asserts (
  input wire logic       ref_clk_i,
  input wire logic       sys_rst_i,
  input wire logic       tck_i,
  input wire logic       trst_n_i,
  input wire logic       power_down_input_i,
  input wire logic       tdo_o,
  input wire logic       tdo_oe_o,
  input wire logic       extest_o,
  input wire logic       outputs_off_o,
  input wire logic       test_active_o,
  input wire logic [3:0] instr_o,
  input wire logic [3:0] state_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_trst_forces_tlr: assert property (
    !trst_n_i [*5] |-> state_o == 4'h0 && instr_o == 4'h2) else $error("test reset ignored");
  a_pd_port_quiet: assert property (
    power_down_input_i [*4] |-> !tdo_oe_o && $stable(state_o)) else $error("port live in pd");
  // Synchroniser delay puts the causing rise two samples back at least
  a_move_on_rise: assert property (
    $changed(state_o) && state_o != 4'h0 |-> $past(tck_i, 2)) else $error("move without rise");
  a_tdo_on_fall: assert property (
    $changed(tdo_o) |-> !$past(tck_i, 2)) else $error("serial out moved off fall");
  a_oe_in_shift: assert property (
    $rose(tdo_oe_o) |-> state_o == 4'h4 || state_o == 4'hB) else $error("oe outside shift");
  a_ir_update_only: assert property (
    $changed(instr_o) |-> state_o == 4'hF || state_o == 4'h0) else $error("stray ir change");
  a_extest_decode: assert property ($stable(instr_o) && $stable(state_o) |->
    extest_o == (instr_o == 4'h0 && state_o != 4'h0)) else $error("extest decode");
  a_highz_decode: assert property ($stable(instr_o) && $stable(state_o) |->
    outputs_off_o == (instr_o == 4'h4 && state_o != 4'h0)) else $error("highz decode");
  a_idle_active: assert property ($stable(instr_o) && $stable(state_o) |->
    test_active_o == (state_o == 4'h1 && (instr_o == 4'h0 || instr_o == 4'h4)))
    else $error("test active decode");
endmodule
bind bst_tap bst_tap_asserts u_chk (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
  .tck_i(tck_i), .trst_n_i(trst_n_i), .power_down_input_i(power_down_input_i),
  .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .extest_o(extest_o), .outputs_off_o(outputs_off_o),
  .test_active_o(test_active_o), .instr_o(instr_o), .state_o(state_o));
`default_nettype wire

// File: test/bst_tester.sv
`timescale 1ns/1ps
`default_nettype none
module bst_tester (
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i
);
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #62.5 tck_o = 1'b1;
    tdo = tdo_i;
    #62.5 tck_o = 1'b0;
    // Released data line flips so a stale bit cannot pass for a good one
    tdi_o = ~tdi;
  endtask
  task automatic reset_tap();
    logic d;
    repeat (5) step(1'b1, 1'b0, d);
  endtask
endmodule
`default_nettype wire

// File: test/bst_tap_bench.sv
`timescale 1ns/1ps
`default_nettype none
module bst_tap_bench;
  localparam logic [3:0]  VER  = 4'h5;     // Arbitrary value
  localparam logic [15:0] PART = 16'h1234; // Arbitrary value
  localparam logic [10:0] MFR  = 11'h2A5;  // Arbitrary value
  logic       clk = 1'b0, rst = 1'b1, trst_n = 1'b1, pd = 1'b0;
  logic       tck, tms, tdi, tdo, tdo_oe, extest, off, active;
  logic [7:0] pins = 8'h00, drive;
  logic [3:0] instr, state;
  logic [3:0] codes [7] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'hF, 4'h2, 4'h7};
  int         err_count = 0, n_compared = 0, seed = 32'hE359;
  always #5 clk = ~clk;
  bst_tap #(.BSR_LEN(8), .ID_VER(VER), .ID_PART(PART), .ID_MFR(MFR)) i_dut (
    .ref_clk_i(clk), .sys_rst_i(rst), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n),
    .power_down_input_i(pd), .pins_in_i(pins), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
    .bsr_drive_o(drive), .extest_o(extest), .outputs_off_o(off), .test_active_o(active),
    .instr_o(instr), .state_o(state));
  bst_tester i_tester (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // TMS levels are taken LSB first
  task automatic mv(input logic [7:0] t, input int n);
    logic d;
    for (int i = 0; i < n; i++) i_tester.step(t[i], 1'($random(seed)), d);
  endtask
  task automatic scan(input logic [31:0] din, input int n, output logic [31:0] dout);
    logic d;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      i_tester.step(i == n - 1, din[i], d);
      dout[i] = d;
    end
  endtask
  task automatic ir(input logic [3:0] code, output logic [31:0] o);
    mv(8'h03, 4);
    scan({28'h0, code}, 4, o);
    mv(8'h01, 2);
  endtask
  task automatic dr(input logic [31:0] din, output logic [31:0] o);
    mv(8'h01, 3);
    scan(din, 32, o);
    mv(8'h01, 2);
  endtask
  function automatic logic [31:0] expect_dr(logic [3:0] c, logic [31:0] d, logic [7:0] p);
    case (c)
      4'h0, 4'h1: return {d[23:0], p};
      4'h2:       return {VER, PART, MFR, 1'b1};
      default:    return {d[30:0], 1'b0};
    endcase
  endfunction
  initial begin
    #500000;
    err_count++;
    wrap_up();
  end
  initial begin
    logic [31:0] o, d;
    repeat (2) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    repeat (4) @(negedge clk);
    for (int k = 0; k < 4; k++) begin
      mv(8'($random(seed)), 8);
      i_tester.reset_tap();
      repeat (5) @(negedge clk);
      check({state, instr}, 8'h02);
      mv(8'h00, 1);
    end
    mv(8'h03, 4);
    scan(32'hF, 2, o);
    mv(8'h04, 4);
    check(o[1:0], 2'b01);
    scan(32'h3, 2, o);
    check(o[1:0], 2'b00);
    mv(8'h01, 2);
    check(instr, 4'hF);
    foreach (codes[k]) begin
      @(negedge clk) pins = 8'($random(seed));
      d = $random(seed);
      ir(codes[k], o);
      check(o[3:0], 4'h1);
      check({instr, off, extest}, {codes[k], codes[k] == 4'h4, codes[k] == 4'h0});
      check(active, codes[k] == 4'h0 || codes[k] == 4'h4);
      dr(d, o);
      check(o, expect_dr(codes[k], d, pins));
      if (codes[k] < 4'h2) check(drive, d[31:24]);
    end
    @(negedge clk) pd = 1'b1;
    mv(8'h01, 3);
    check({state, tdo_oe}, 5'h02);
    @(negedge clk) pd = 1'b0;
    repeat (5) @(negedge clk);
    mv(8'h01, 3);
    repeat (5) @(negedge clk);
    check({state, tdo_oe}, 5'h09);
    @(negedge clk) trst_n = 1'b0;
    repeat (6) @(negedge clk);
    check({state, instr, tdo_oe}, 9'h004);
    trst_n = 1'b1;
    repeat (5) @(negedge clk);
    wrap_up();
  end
endmodule
`default_nettype wire
